// ---- include/pwc_params.svh ----
// Register map, field positions, limits and reset values of the converter
`ifndef PWC_PARAMS_SVH
`define PWC_PARAMS_SVH

// Register byte offsets
`define PWC_ADDR_CTRL    8'h00
`define PWC_ADDR_IN_MAG  8'h04
`define PWC_ADDR_IN_FRAC 8'h08
`define PWC_ADDR_IN_W0   8'h0c
`define PWC_ADDR_IN_W1   8'h10
`define PWC_ADDR_OUT_W0  8'h14
`define PWC_ADDR_OUT_W1  8'h18
`define PWC_ADDR_RESULT  8'h1c
`define PWC_ADDR_STATUS  8'h20

// Control and input field positions
`define PWC_CTRL_START   0
`define PWC_CTRL_DIR     1
`define PWC_CTRL_FMT_LSB 2
`define PWC_FRAC_SIGN    31

// Status field positions
`define PWC_STAT_BUSY    0
`define PWC_STAT_DONE    1
`define PWC_STAT_ERR     2
`define PWC_STAT_OVF     3
`define PWC_STAT_UNF     4

// Range limits of the formats
`define PWC_MAX_BIN      32'd65535
`define PWC_MAX_BCD3     32'd999
`define PWC_MAX_BCD4     32'd9999
`define PWC_MAX_OCT      32'd4095
`define PWC_MAX_BCD6     32'd999999
`define PWC_MAX_FRAC     10'd999

// Default indicator bit positions in the upper word
`define PWC_SGN_BIT      15
`define PWC_OVF_BIT      14
`define PWC_UNF_BIT      13

// Reset values
`define PWC_RST_WORD     32'h0000_0000
`define PWC_RST_HALF     16'h0000

`endif

// ---- include/pwc_pkg.sv ----
// Types shared by the word format converter
package pwc_pkg;

    typedef enum logic [2:0] {
        FMT_BIN,
        FMT_BCD3,
        FMT_BCD4,
        FMT_OCT,
        FMT_BCD6,
        FMT_FIX33
    } pwc_fmt_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BUSY
    } pwc_fsm_t;

    typedef struct packed {
        pwc_fsm_t    st;
        logic        start;
        logic        dir;
        logic [2:0]  fmt;
        logic [31:0] mag;
        logic [9:0]  frac;
        logic        sgn;
        logic [15:0] win0;
        logic [15:0] win1;
        logic [15:0] w0;
        logic [15:0] w1;
        logic [31:0] res;
        logic [15:0] flg;
        logic        oor;
        logic        done;
        logic        err;
        logic        ovf;
        logic        unf;
        logic        dd_go;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } pwc_state_t;

endpackage

// ---- src/pwc_dd.sv ----
// Sequential binary to packed BCD converter (shift and add three)
`timescale 1ns/100ps
module pwc_dd #(
    parameter int W = 20,
    parameter int D = 6
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Request
    input  wire logic             start,
    input  wire logic [W-1:0]     bin,
    // Answer
    output logic      [4*D-1:0]   bcd,
    output logic                  done
);

    localparam int CW = $clog2(W + 1);

    typedef struct packed {
        logic [4*D+W-1:0] sh;
        logic [CW-1:0]    cnt;
        logic             run;
        logic             done;
    } pwc_dd_t;

    pwc_dd_t q;
    pwc_dd_t n;

    // Refuse shapes the shifter cannot serve
    if (W < 1 || D < 1) begin : g_chk
        $error("pwc_dd: W and D must be at least one");
    end

    // One shift per cycle, digits of five or more get three added first
    always_comb begin
        logic [4*D+W-1:0] t;
        t = q.sh;
        n = q;
        n.done = 1'b0;
        if (start) begin
            n.sh  = {{(4*D){1'b0}}, bin};
            n.cnt = CW'(W);
            n.run = 1'b1;
        end else if (q.run) begin
            for (int i = 0; i < D; i++) begin
                if (t[W+4*i +: 4] >= 4'd5) begin
                    t[W+4*i +: 4] = t[W+4*i +: 4] + 4'd3;
                end
            end
            n.sh  = {t[4*D+W-2:0], 1'b0};
            n.cnt = q.cnt - CW'(1);
            if (q.cnt == CW'(1)) begin
                n.run  = 1'b0;
                n.done = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // Digits held until the next start
    assign bcd  = q.sh[4*D+W-1 -: 4*D];
    assign done = q.done;

endmodule

// ---- src/pwc_conv.sv ----
// Word format converter with an APB register slave
//
// Overview of operation
// RULE_01 - Binary format: one straight 16-bit word, values 0 to 65535, no flags.
// RULE_02 - Negative or above 65535 into binary raises argument rejected error.
// RULE_03 - Signed 3-digit format: one word, packed BCD plus sign and range flags.
// RULE_04 - Signed 3-digit accepts -999..+999; outside sets over/underflow, digits 000.
// RULE_05 - Integer formats drop the fraction by truncation, never rounding.
// RULE_06 - Unsigned 4-digit BCD 0..9999, no flags; above 9999 emits 0000.
// RULE_07 - Signed octal: 4 octal digits, range plus or minus 4095, with flags.
// RULE_08 - Octal out of range sets over/underflow flag and emits 0000.
// RULE_09 - Signed 6-digit: word 0 flags and high digits, word 1 low digits.
// RULE_10 - 6-digit accepts up to 999999; outside sets flag, emits 000000.
// RULE_11 - Fixed 3.3: word 0 flags, sign, integer digits; word 1 fraction digits.
// RULE_12 - Fixed 3.3 keeps three fraction places; out of range emits 000.000.
// RULE_13 - Decode all formats but fixed 3.3, same layouts as encoding.
// RULE_14 - Signed decode applies received sign; unsigned decode is non-negative.
// RULE_15 - Sign, overflow, underflow positions are parameters, top bits by default.
// RULE_16 - Indicator bits not set by this conversion are cleared.
`timescale 1ns/100ps
`include "pwc_params.svh"
module pwc_conv #(
    parameter int SGN_BIT = `PWC_SGN_BIT,
    parameter int OVF_BIT = `PWC_OVF_BIT,
    parameter int UNF_BIT = `PWC_UNF_BIT
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);

    pwc_pkg::pwc_state_t q;
    pwc_pkg::pwc_state_t n;

    logic [23:0] ibcd;
    logic        idone;
    logic [11:0] fbcd;

    // Flags must sit above the twelve digit bits and be distinct
    if (SGN_BIT < 12 || SGN_BIT > 15 || OVF_BIT < 12 || OVF_BIT > 15 ||
        UNF_BIT < 12 || UNF_BIT > 15 || SGN_BIT == OVF_BIT ||
        SGN_BIT == UNF_BIT || OVF_BIT == UNF_BIT) begin : g_chk
        $error("pwc_conv: indicator bit positions invalid");
    end

    // Build an indicator word from scratch each time
    function automatic logic [15:0] flag_word(input logic s,
                                              input logic o,
                                              input logic u);
        logic [15:0] f;
        f = `PWC_RST_HALF;
        f[SGN_BIT] = s; // RULE_15
        f[OVF_BIT] = o;
        f[UNF_BIT] = u;
        return f;
    endfunction

    // Value of three packed BCD digits
    function automatic logic [19:0] bcd3v(input logic [11:0] x);
        return 20'(x[11:8]) * 20'd100 + 20'(x[7:4]) * 20'd10 + 20'(x[3:0]);
    endfunction

    // Integer part digits; only in-range magnitudes are converted
    pwc_dd #(
        .W (20),
        .D (6)
    ) u_int_dd (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (q.dd_go),
        .bin     (q.oor ? 20'h00000 : q.mag[19:0]),
        .bcd     (ibcd),
        .done    (idone)
    );

    // Fraction digits in thousandths
    pwc_dd #(
        .W (10),
        .D (3)
    ) u_frac_dd (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (q.dd_go),
        .bin     (q.frac),
        .bcd     (fbcd),
        .done    ()
    );

    // Next state: bus access, conversion launch and result assembly
    always_comb begin
        logic        neg;
        logic [31:0] lim;
        logic        oor;
        logic [19:0] m;
        logic        s;
        logic [23:0] d;
        neg = q.sgn & ((q.mag != 32'h0) | (q.frac != 10'h0));
        lim = `PWC_MAX_BCD6;
        oor = 1'b0;
        m   = 20'h00000;
        s   = 1'b0;
        d   = q.oor ? 24'h000000 : ibcd;
        n   = q;
        n.dd_go   = 1'b0;
        n.pready  = 1'b0;
        n.pslverr = 1'b0;
        n.prdata  = `PWC_RST_WORD;

        // Setup phase: prepare the answer for the access phase
        if (psel && !penable) begin
            n.pready = 1'b1;
            case (paddr)
                `PWC_ADDR_CTRL:    n.prdata = {27'h0, q.fmt, q.dir, 1'b0};
                `PWC_ADDR_IN_MAG:  n.prdata = q.mag;
                `PWC_ADDR_IN_FRAC: n.prdata = {q.sgn, 21'h0, q.frac};
                `PWC_ADDR_IN_W0:   n.prdata = {16'h0, q.win0};
                `PWC_ADDR_IN_W1:   n.prdata = {16'h0, q.win1};
                `PWC_ADDR_OUT_W0:  n.prdata = {16'h0, q.w0};
                `PWC_ADDR_OUT_W1:  n.prdata = {16'h0, q.w1};
                `PWC_ADDR_RESULT:  n.prdata = q.res;
                `PWC_ADDR_STATUS:  begin
                    n.prdata[`PWC_STAT_BUSY] =
                        (q.st != pwc_pkg::ST_IDLE) | q.start;
                    n.prdata[`PWC_STAT_DONE] = q.done;
                    n.prdata[`PWC_STAT_ERR]  = q.err;
                    n.prdata[`PWC_STAT_OVF]  = q.ovf;
                    n.prdata[`PWC_STAT_UNF]  = q.unf;
                end
                default: n.pslverr = 1'b1;
            endcase
        end

        // Access phase: writes take effect at this edge only
        if (psel && penable && q.pready && pwrite) begin
            case (paddr)
                `PWC_ADDR_CTRL: begin
                    if (q.st == pwc_pkg::ST_IDLE && !q.start) begin
                        n.dir   = pwdata[`PWC_CTRL_DIR];
                        n.fmt   = pwdata[`PWC_CTRL_FMT_LSB +: 3];
                        n.start = pwdata[`PWC_CTRL_START];
                    end
                end
                `PWC_ADDR_IN_MAG:  n.mag  = pwdata;
                `PWC_ADDR_IN_FRAC: begin
                    n.frac = pwdata[9:0];
                    n.sgn  = pwdata[`PWC_FRAC_SIGN];
                end
                `PWC_ADDR_IN_W0:   n.win0 = pwdata[15:0];
                `PWC_ADDR_IN_W1:   n.win1 = pwdata[15:0];
                default: ;
            endcase
        end

        case (q.st)
            pwc_pkg::ST_IDLE: begin
                if (q.start) begin
                    // Fresh result: flags and output words cleared; res keeps its value until a decode
                    n.start = 1'b0;
                    n.done  = 1'b0;
                    n.err   = 1'b0;
                    n.ovf   = 1'b0; // RULE_16
                    n.unf   = 1'b0; // RULE_16
                    n.w0    = `PWC_RST_HALF; // RULE_16
                    n.w1    = `PWC_RST_HALF;
                    n.flg   = `PWC_RST_HALF;
                    n.oor   = 1'b0;
                    if (q.dir) begin
                        // Decode one or two received words
                        n.done = 1'b1;
                        case (q.fmt)
                            pwc_pkg::FMT_BIN:  m = {4'h0, q.win0}; // RULE_13
                            pwc_pkg::FMT_BCD3: begin
                                m = bcd3v(q.win0[11:0]); // RULE_13
                                s = q.win0[SGN_BIT]; // RULE_14
                            end
                            pwc_pkg::FMT_BCD4: begin
                                m = 20'(q.win0[15:12]) * 20'd1000 +
                                    bcd3v(q.win0[11:0]); // RULE_14
                            end
                            pwc_pkg::FMT_OCT:  begin
                                m = {8'h0, q.win0[11:0]}; // RULE_13
                                s = q.win0[SGN_BIT]; // RULE_14
                            end
                            pwc_pkg::FMT_BCD6: begin
                                m = bcd3v(q.win0[11:0]) * 20'd1000 +
                                    bcd3v(q.win1[11:0]); // RULE_13
                                s = q.win0[SGN_BIT]; // RULE_14
                            end
                            default: n.err = 1'b1; // RULE_13
                        endcase
                        n.res = s ? 32'h0 - {12'h0, m} : {12'h0, m};
                    end else begin
                        // Encode: integer formats drop the fraction; binary rejects one above 999
                        case (q.fmt)
                            pwc_pkg::FMT_BIN:   lim = `PWC_MAX_BIN;
                            pwc_pkg::FMT_BCD3:  lim = `PWC_MAX_BCD3;
                            pwc_pkg::FMT_BCD4:  lim = `PWC_MAX_BCD4;
                            pwc_pkg::FMT_OCT:   lim = `PWC_MAX_OCT;
                            pwc_pkg::FMT_FIX33: lim = `PWC_MAX_BCD3;
                            default:            lim = `PWC_MAX_BCD6;
                        endcase
                        oor = (q.mag > lim); // RULE_05
                        case (q.fmt)
                            pwc_pkg::FMT_BIN: begin
                                n.done = 1'b1;
                                if (neg || oor || q.frac > `PWC_MAX_FRAC) begin
                                    n.err = 1'b1; // RULE_02
                                end else begin
                                    n.w0 = q.mag[15:0]; // RULE_01
                                end
                            end
                            pwc_pkg::FMT_BCD4: begin
                                n.oor   = oor | neg; // RULE_06
                                n.dd_go = 1'b1;
                                n.st    = pwc_pkg::ST_BUSY;
                            end
                            pwc_pkg::FMT_OCT: begin
                                n.done = 1'b1;
                                n.ovf  = oor & ~neg; // RULE_08
                                n.unf  = oor & neg; // RULE_08
                                n.w0   = flag_word(neg & ~oor, oor & ~neg,
                                                   oor & neg) |
                                         (oor ? 16'h0000 :
                                          {4'h0, q.mag[11:0]}); // RULE_07
                            end
                            pwc_pkg::FMT_BCD3,
                            pwc_pkg::FMT_BCD6,
                            pwc_pkg::FMT_FIX33: begin
                                n.oor   = oor; // RULE_04 RULE_10 RULE_12
                                n.ovf   = oor & ~neg;
                                n.unf   = oor & neg;
                                n.flg   = flag_word(neg & ~oor, oor & ~neg,
                                                    oor & neg);
                                n.dd_go = 1'b1;
                                n.st    = pwc_pkg::ST_BUSY;
                            end
                            default: begin
                                n.done = 1'b1;
                                n.err  = 1'b1;
                            end
                        endcase
                    end
                end
            end
            pwc_pkg::ST_BUSY: begin
                // Both converters start together; integer one ends last
                if (idone) begin
                    n.st   = pwc_pkg::ST_IDLE;
                    n.done = 1'b1;
                    case (q.fmt)
                        pwc_pkg::FMT_BCD3: begin
                            n.w0 = q.flg | {4'h0, d[11:0]}; // RULE_03 RULE_04
                        end
                        pwc_pkg::FMT_BCD4: begin
                            n.w0 = d[15:0]; // RULE_06
                        end
                        pwc_pkg::FMT_BCD6: begin
                            n.w0 = q.flg | {4'h0, d[23:12]}; // RULE_09
                            n.w1 = {4'h0, d[11:0]}; // RULE_09 RULE_10
                        end
                        pwc_pkg::FMT_FIX33: begin
                            n.w0 = q.flg | {4'h0, d[11:0]}; // RULE_11
                            n.w1 = q.oor ? 16'h0000 :
                                   {4'h0, fbcd}; // RULE_11 RULE_12
                        end
                        default: n.err = 1'b1;
                    endcase
                end
            end
            default: n.st = pwc_pkg::ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // Bus answers straight from flops
    assign prdata  = q.prdata;
    assign pready  = q.pready;
    assign pslverr = q.pslverr;

endmodule

// ---- test/pwc_conv_asserts.sv ----
// Checker of the converter's APB port and read word layouts
`timescale 1ns/100ps
`include "pwc_params.svh"
module pwc_conv_chk (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB slave port
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Transfer phases
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_rd(logic [7:0] a);
        pready && !pwrite && paddr == a;
    endsequence

    property p_ack;
        s_setup |=> pready && penable;
    endproperty
    a_ack: assert property (p_ack)
        else $error("no ready after setup");
    property p_lone;
        pready |-> $past(psel) && !$past(penable);
    endproperty
    a_lone: assert property (p_lone)
        else $error("ready without setup");
    property p_idle;
        !pready |-> prdata == 32'h0 && !pslverr;
    endproperty
    a_idle: assert property (p_idle)
        else $error("read data outside access");
    property p_unmap;
        pready && paddr > `PWC_ADDR_STATUS |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped access not refused");
    property p_map;
        pready && paddr <= `PWC_ADDR_STATUS |-> !pslverr;
    endproperty
    a_map: assert property (p_map)
        else $error("mapped access refused");
    property p_stat;
        s_rd(`PWC_ADDR_STATUS) |-> prdata[31:5] == 27'h0
            && !(prdata[3] && prdata[4]) && !(prdata[2] && prdata[4:3] != 0);
    endproperty
    a_stat: assert property (p_stat)
        else $error("stale or clashing status flags");
    property p_w0;
        s_rd(`PWC_ADDR_OUT_W0) |-> prdata[31:16] == 16'h0;
    endproperty
    a_w0: assert property (p_w0)
        else $error("word 0 wider than 16 bits");
    property p_w1;
        s_rd(`PWC_ADDR_OUT_W1) |-> prdata[31:12] == 20'h0;
    endproperty
    a_w1: assert property (p_w1)
        else $error("word 1 carries more than three digits");
    property p_ctrl;
        s_rd(`PWC_ADDR_CTRL) |-> !prdata[0];
    endproperty
    a_ctrl: assert property (p_ctrl)
        else $error("start bit reads back set");
endmodule

bind pwc_conv pwc_conv_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ---- test/pwc_apb_host.sv ----
// APB master standing in for the controller processor
`timescale 1ns/100ps
module pwc_apb_host (
    // Clock
    input wire logic        pclk,
    // APB master port
    output logic            psel,
    output logic            penable,
    output logic            pwrite,
    output logic [7:0]      paddr,
    output logic [31:0]     pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    // Idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // One transfer, request held until pready is seen high, for at most 16 cycles
    task automatic xfer(input logic wr, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r,
            output logic e, output logic ok);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        ok = 1'b0;
        for (n = 0; n < 16 && ok !== 1'b1; n++) begin
            @(posedge pclk);
            ok = pready;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench of the word format converter
`timescale 1ns/100ps
`include "pwc_params.svh"
module tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, ev;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rv, last;
    int          failures = 0;
    int          n_checks = 0;
    int          seed = 5328;
    int          lim[6] = '{65535, 999, 9999, 4095, 999999, 999};

    // 40 MHz clock
    always #12.5 pclk = ~pclk;

    pwc_apb_host host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    pwc_conv dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // Verdict and end of run
    task automatic end_of_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Compare one value
    task automatic chk(input string nm, input logic [31:0] ex,
            input logic [31:0] got);
        n_checks++;
        if (got !== ex) begin
            failures++;
            $display("CHECK FAILED %s exp %h got %h", nm, ex, got);
        end
    endtask

    // Bus transfer; a hung slave ends the run
    task automatic bus(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        logic ok;
        host.xfer(wr, a, d, rv, ev, ok);
        if (ok !== 1'b1) begin
            failures++;
            $display("CHECK FAILED pready exp 1 got 0");
            end_of_test;
        end
    endtask

    // Start a conversion and poll until done
    task automatic run(input logic dir, input logic [2:0] f);
        int n;
        bus(1'b1, `PWC_ADDR_CTRL, {27'h0, f, dir, 1'b1});
        rv = 32'h0;
        for (n = 0; n < 40 && rv[1] !== 1'b1; n++)
            bus(1'b0, `PWC_ADDR_STATUS, 32'h0);
        chk("done", 32'h2, rv & 32'h3);
        // A conversion that never ends closes the run
        if (rv[1] !== 1'b1)
            end_of_test;
    endtask

    // Decimal to packed BCD
    function automatic logic [31:0] to_bcd(input int v);
        logic [31:0] b;
        b = 32'h0;
        for (int i = 0; i < 8; i++) begin
            b[4*i +: 4] = 4'(v % 10);
            v = v / 10;
        end
        return b;
    endfunction

    // Expected words and flags {unf, ovf, err} of an encode
    function automatic void enc(input logic [2:0] f, input int m,
            input int fr, input logic s, output logic [15:0] w0,
            output logic [15:0] w1, output logic [2:0] fl);
        logic [31:0] b, c;
        b = to_bcd(m);
        c = to_bcd(fr);
        w0 = 16'h0;
        w1 = 16'h0;
        fl = 3'b000;
        if (f == 3'd0) begin
            if (s || m > lim[0] || fr > 999)
                fl = 3'b001;
            else
                w0 = 16'(m);
        end else if (f == 3'd2) begin
            if (!s && m <= lim[2])
                w0 = b[15:0];
        end else if (m > lim[f]) begin
            fl = s ? 3'b100 : 3'b010;
            w0 = 16'h1 << (s ? `PWC_UNF_BIT : `PWC_OVF_BIT);
        end else begin
            w0 = f == 3'd3 ? 16'(m) : {4'h0, b[(f == 3'd4 ? 12 : 0) +: 12]};
            w0[`PWC_SGN_BIT] = s;
            w1 = f == 3'd4 ? {4'h0, b[11:0]} : 16'h0;
            if (f == 3'd5)
                w1 = {4'h0, c[11:0]};
        end
    endfunction

    // Encode and compare status and both words
    task automatic do_enc(input logic [2:0] f, input int m, input int fr,
            input logic s);
        logic [15:0] w0, w1;
        logic [2:0]  fl;
        enc(f, m, fr, s, w0, w1, fl);
        bus(1'b1, `PWC_ADDR_IN_MAG, 32'(m));
        bus(1'b1, `PWC_ADDR_IN_FRAC, {s, 21'h0, 10'(fr)});
        run(1'b0, f);
        chk("status", {27'h0, fl, 2'b10}, rv);
        bus(1'b0, `PWC_ADDR_OUT_W0, 32'h0);
        chk("out_w0", {16'h0, w0}, rv);
        bus(1'b0, `PWC_ADDR_OUT_W1, 32'h0);
        chk("out_w1", {16'h0, w1}, rv);
    endtask

    // Decode words built from a known value
    task automatic do_dec(input logic [2:0] f, input int m, input logic s);
        logic [15:0] w0, w1;
        logic [2:0]  fl;
        enc(f, m, 0, s, w0, w1, fl);
        bus(1'b1, `PWC_ADDR_IN_W0, {16'h0, w0});
        bus(1'b1, `PWC_ADDR_IN_W1, {16'h0, w1});
        run(1'b1, f);
        bus(1'b0, `PWC_ADDR_RESULT, 32'h0);
        last = 32'(s ? -m : m);
        chk("result", last, rv);
    endtask

    // Main sequence
    initial begin
        int m, r, k;
        logic [2:0] f;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, two unmapped places and a read-only word
        for (int a = 0; a <= 'h24; a += 4) begin
            bus(1'b0, 8'(a), 32'h0);
            chk("reset", 32'h0, rv);
            chk("slverr", 32'(a > 'h20), 32'(ev));
        end
        bus(1'b1, 8'hfc, 32'hffff_ffff);
        chk("slverr", 32'h1, 32'(ev));
        bus(1'b1, `PWC_ADDR_OUT_W0, 32'hffff_ffff);
        bus(1'b0, `PWC_ADDR_OUT_W0, 32'h0);
        chk("ro_w0", 32'h0, rv);
        // Encode: limits, one past, zero, then random
        for (int i = 0; i < 72; i++) begin
            f = 3'(i % 6);
            k = i / 6;
            r = $random(seed);
            m = k < 2 ? lim[f] : k < 4 ? lim[f] + 1 : k < 5 ? 0
                : (r & 'hfffff) % (2 * lim[f] + 2);
            do_enc(f, m, k < 2 ? 999 : (r >>> 8 & 'h3ff) % 1000,
                k < 4 ? k[0] : r[31] && m != 0);
        end
        // Start during a long conversion is ignored
        do_enc(3'd4, 123456, 0, 1'b1);
        bus(1'b1, `PWC_ADDR_CTRL, 32'h11);
        run(1'b0, 3'd0);
        bus(1'b0, `PWC_ADDR_OUT_W0, 32'h0);
        chk("busy_w0", 32'h8123, rv);
        // Unknown format codes are rejected
        for (int c = 6; c < 8; c++) begin
            run(1'b0, 3'(c));
            chk("bad_fmt", 32'h6, rv);
        end
        // Decode of every format that has one
        for (int i = 0; i < 60; i++) begin
            f = 3'(i % 5);
            r = $random(seed);
            m = i < 10 ? lim[f] : (r & 'hfffff) % (lim[f] + 1);
            do_dec(f, m, f != 0 && f != 2 && m != 0 && (i < 10 || r[31]));
        end
        run(1'b1, 3'd5);
        chk("fix_dec", 32'h6, rv);
        bus(1'b0, `PWC_ADDR_RESULT, 32'h0);
        // A rejected decode leaves a cleared result
        chk("fix_res", 32'h0, rv);
        end_of_test;
    end
endmodule
